/* File: core/ulwp_pkg.sv */
package ulwp_pkg;
    // Register byte offsets
    localparam logic [7:0] ULWP_OFF_MODE      = 8'h00;
    localparam logic [7:0] ULWP_OFF_BAUDGEN   = 8'h20;
    localparam logic [7:0] ULWP_OFF_RXTIMEOUT = 8'h24;
    localparam logic [7:0] ULWP_OFF_TIMEGUARD = 8'h28;
    localparam logic [7:0] ULWP_OFF_CLKRATIO  = 8'h40;
    localparam logic [7:0] ULWP_OFF_IRFILTER  = 8'h4C;
    localparam logic [7:0] ULWP_OFF_MANCH     = 8'h50;
    localparam logic [7:0] ULWP_OFF_LINMODE   = 8'h54;
    localparam logic [7:0] ULWP_OFF_IDENT     = 8'h58;
    localparam logic [7:0] ULWP_OFF_BAUDRB    = 8'h5C;
    localparam logic [7:0] ULWP_OFF_IRQ_STAT  = 8'hD0;
    localparam logic [7:0] ULWP_OFF_IRQ_CLR   = 8'hD4;
    localparam logic [7:0] ULWP_OFF_IRQ_EN    = 8'hD8;
    localparam logic [7:0] ULWP_OFF_WPMODE    = 8'hE4;
    localparam logic [7:0] ULWP_OFF_WPSTAT    = 8'hE8;
    localparam logic [7:0] ULWP_OFF_REVISION  = 8'hFC;

    // Operating mode codes
    localparam logic [3:0] ULWP_MODE_LIN_MASTER = 4'hA;
    localparam logic [3:0] ULWP_MODE_LIN_SLAVE  = 4'hB;

    // Field layout
    localparam int ULWP_MODE_LSB       = 0;
    localparam int ULWP_RTO_W          = 17;
    localparam int ULWP_ACT_LSB        = 0;
    localparam int ULWP_KEY_LSB        = 8;
    localparam int ULWP_VSRC_LSB       = 8;
    localparam logic [23:0] ULWP_PROTECT_KEY = 24'h55_5341;

    // Reset values
    localparam logic [31:0] ULWP_RST_ZERO  = 32'h0000_0000;
    localparam logic [31:0] ULWP_RST_MANCH = 32'h3001_1004;
    // Arbitrary neutral revision code
    localparam logic [31:0] ULWP_REVISION  = 32'h0000_0101;

    // Clock divider
    localparam int ULWP_DIV_FACTOR = 8;
    localparam int ULWP_DIV_W      = 3;

    // Interrupt status bits
    localparam int ULWP_IRQ_VIOL  = 0;
    localparam int ULWP_IRQ_IDENT = 1;
    localparam int ULWP_IRQ_SYNC  = 2;
    localparam int ULWP_IRQ_W     = 3;

    typedef enum logic [1:0] {
        ULWP_ACT_PUBLISH   = 2'b00,
        ULWP_ACT_SUBSCRIBE = 2'b01,
        ULWP_ACT_IGNORE    = 2'b10,
        ULWP_ACT_RESERVED  = 2'b11
    } ulwp_action_t;
endpackage

/* File: core/ulwp_clkdiv.sv */
`timescale 1ns/1ns
module ulwp_clkdiv (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Divided enable
    output logic      tick_o
);
    import ulwp_pkg::*;

    logic [ULWP_DIV_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
            tick_o <= (cnt_q == ULWP_DIV_W'(ULWP_DIV_FACTOR - 1));
        end
    end
endmodule

/* File: core/ulwp_protect.sv */
`timescale 1ns/1ns
module ulwp_protect (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Decoded accesses
    input  wire logic        wr_mode_i,
    input  wire logic        wr_prot_i,
    input  wire logic [7:0]  wr_off_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        rd_stat_i,
    // State
    output logic             enable_o,
    output logic             flag_o,
    output logic [15:0]      source_o,
    output logic             viol_o
);
    import ulwp_pkg::*;

    logic key_ok;
    logic viol;

    assign key_ok = (wdata_i[31:ULWP_KEY_LSB] == ULWP_PROTECT_KEY);
    assign viol   = wr_prot_i && enable_o;
    assign viol_o = viol;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_o <= 1'b0;
        end else if (wr_mode_i && key_ok) begin
            enable_o <= wdata_i[0];
        end
    end

    // A violation in the same cycle as the clearing read survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_o   <= 1'b0;
            source_o <= '0;
        end else if (viol) begin
            flag_o   <= 1'b1;
            source_o <= {8'h00, wr_off_i};
        end else if (rd_stat_i) begin
            flag_o   <= 1'b0;
            source_o <= '0;
        end
    end
endmodule

/* File: core/ulwp_regs.sv */
`timescale 1ns/1ns
module ulwp_regs (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // LIN engine side
    input  wire logic                  ident_rx_valid_i,
    input  wire logic [7:0]            ident_rx_i,
    input  wire logic                  sync_done_i,
    input  wire logic [15:0]           sync_clock_divider_i,
    input  wire logic [2:0]            sync_frac_part_i,
    output ulwp_pkg::ulwp_action_t     response_action_o,
    output logic      [7:0]            ident_tx_o,
    output logic      [3:0]            mode_o,
    output logic      [ulwp_pkg::ULWP_RTO_W-1:0] receiver_timeout_value_o,
    output logic                       div_tick_o,
    // Interrupt
    output logic                       irq_o
);
    import ulwp_pkg::*;

    logic [31:0] mode_q;
    logic [31:0] baudgen_q;
    logic [ULWP_RTO_W-1:0] rto_q;
    logic [31:0] tguard_q;
    logic [31:0] ratio_q;
    logic [31:0] irfilt_q;
    logic [31:0] manch_q;
    logic [31:0] linmode_q;
    logic [7:0]  ident_q;
    logic [15:0] cd_q;
    logic [2:0]  fp_q;
    logic [ULWP_IRQ_W-1:0] ist_q;
    logic [ULWP_IRQ_W-1:0] ien_q;

    logic        req;
    logic        wr;
    logic        rd;
    logic        wr_prot;
    logic        prot_en;
    logic        viol_flag;
    logic [15:0] viol_src;
    logic        viol_evt;
    logic        tick;
    logic [31:0] rdata;
    logic [31:0] wmask;
    logic        is_master;
    logic        is_slave;
    logic [ULWP_IRQ_W-1:0] ev;
    logic        cfg_we;
    logic        wr_wpmode;
    logic        rd_wpstat;
    logic        wr_linmode;
    logic        wr_ident;
    logic        wr_irq_clr;
    logic        wr_irq_en;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i;
    assign rd  = req && !wb_we_i;

    // Per-register strobes
    assign wr_wpmode  = wr && (wb_adr_i == ULWP_OFF_WPMODE);
    assign rd_wpstat  = rd && (wb_adr_i == ULWP_OFF_WPSTAT);
    assign wr_linmode = wr && (wb_adr_i == ULWP_OFF_LINMODE);
    assign wr_ident   = wr && (wb_adr_i == ULWP_OFF_IDENT) && wb_sel_i[0];
    assign wr_irq_clr = wr && (wb_adr_i == ULWP_OFF_IRQ_CLR) && wb_sel_i[0];
    assign wr_irq_en  = wr && (wb_adr_i == ULWP_OFF_IRQ_EN) && wb_sel_i[0];
    // Protected writes land only while protection is off; still acked either way
    assign cfg_we     = wr_prot && !prot_en;

    assign is_master = (mode_q[3:0] == ULWP_MODE_LIN_MASTER);
    assign is_slave  = (mode_q[3:0] == ULWP_MODE_LIN_SLAVE);

    // Byte-lane mask from select lines
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
        end
    endgenerate

    // Protected set
    always_comb begin
        unique case (wb_adr_i)
            ULWP_OFF_MODE,
            ULWP_OFF_BAUDGEN,
            ULWP_OFF_RXTIMEOUT,
            ULWP_OFF_TIMEGUARD,
            ULWP_OFF_CLKRATIO,
            ULWP_OFF_IRFILTER,
            ULWP_OFF_MANCH: wr_prot = wr;
            default: wr_prot = 1'b0;
        endcase
    end

    ulwp_protect u_protect (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_mode_i (wr_wpmode),
        .wr_prot_i (wr_prot),
        .wr_off_i  (wb_adr_i),
        .wdata_i   (wb_dat_i),
        .rd_stat_i (rd_wpstat),
        .enable_o  (prot_en),
        .flag_o    (viol_flag),
        .source_o  (viol_src),
        .viol_o    (viol_evt)
    );

    ulwp_clkdiv u_clkdiv (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_tick_o <= 1'b0;
        end else begin
            div_tick_o <= tick;
        end
    end

    // Configuration registers, one block each; writes dropped while enabled, except LINMODE, which is unprotected
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= ULWP_RST_ZERO;
        end else if (cfg_we && wb_adr_i == ULWP_OFF_MODE) begin
            mode_q <= (mode_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baudgen_q <= ULWP_RST_ZERO;
        end else if (cfg_we && wb_adr_i == ULWP_OFF_BAUDGEN) begin
            baudgen_q <= (baudgen_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    // Only the low 17 bits exist; upper write data is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rto_q <= '0;
        end else if (cfg_we && wb_adr_i == ULWP_OFF_RXTIMEOUT) begin
            rto_q <= (rto_q & ~wmask[ULWP_RTO_W-1:0])
                   | (wb_dat_i[ULWP_RTO_W-1:0] & wmask[ULWP_RTO_W-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tguard_q <= ULWP_RST_ZERO;
        end else if (cfg_we && wb_adr_i == ULWP_OFF_TIMEGUARD) begin
            tguard_q <= (tguard_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ratio_q <= ULWP_RST_ZERO;
        end else if (cfg_we && wb_adr_i == ULWP_OFF_CLKRATIO) begin
            ratio_q <= (ratio_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irfilt_q <= ULWP_RST_ZERO;
        end else if (cfg_we && wb_adr_i == ULWP_OFF_IRFILTER) begin
            irfilt_q <= (irfilt_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            manch_q <= ULWP_RST_MANCH;
        end else if (cfg_we && wb_adr_i == ULWP_OFF_MANCH) begin
            manch_q <= (manch_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            linmode_q <= ULWP_RST_ZERO;
        end else if (wr_linmode) begin
            linmode_q <= (linmode_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    // Identifier: software in master mode, bus receiver in slave mode
    // Capture takes priority, so a bus write can never mask a received identifier
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ident_q <= 8'h00;
        end else if (is_slave && ident_rx_valid_i) begin
            ident_q <= ident_rx_i;
        end else if (is_master && wr_ident) begin
            ident_q <= wb_dat_i[7:0];
        end
    end

    // Synchronization result; bus writes never reach it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cd_q <= 16'h0000;
        end else if (sync_done_i) begin
            cd_q <= sync_clock_divider_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fp_q <= 3'h0;
        end else if (sync_done_i) begin
            fp_q <= sync_frac_part_i;
        end
    end

    // Sticky interrupt status; set wins over clear
    assign ev[ULWP_IRQ_VIOL]  = viol_evt;
    assign ev[ULWP_IRQ_IDENT] = is_slave && ident_rx_valid_i;
    assign ev[ULWP_IRQ_SYNC]  = sync_done_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= '0;
        end else if (wr_irq_clr) begin
            ist_q <= (ist_q & ~wb_dat_i[ULWP_IRQ_W-1:0]) | ev;
        end else begin
            ist_q <= ist_q | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien_q <= '0;
        end else if (wr_irq_en) begin
            ien_q <= wb_dat_i[ULWP_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ist_q & ien_q);
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            ULWP_OFF_MODE:      rdata = mode_q;
            ULWP_OFF_BAUDGEN:   rdata = baudgen_q;
            ULWP_OFF_RXTIMEOUT: rdata = {15'h0000, rto_q};
            ULWP_OFF_TIMEGUARD: rdata = tguard_q;
            ULWP_OFF_CLKRATIO:  rdata = ratio_q;
            ULWP_OFF_IRFILTER:  rdata = irfilt_q;
            ULWP_OFF_MANCH:     rdata = manch_q;
            ULWP_OFF_LINMODE:   rdata = linmode_q;
            ULWP_OFF_IDENT:     rdata = {24'h00_0000, ident_q};
            ULWP_OFF_BAUDRB:    rdata = {13'h0000, fp_q, cd_q};
            ULWP_OFF_IRQ_STAT:  rdata = {29'h0000_0000, ist_q};
            ULWP_OFF_IRQ_EN:    rdata = {29'h0000_0000, ien_q};
            ULWP_OFF_WPMODE:    rdata = {31'h0000_0000, prot_en};
            ULWP_OFF_WPSTAT:    rdata = {8'h00, viol_src, 7'h00, viol_flag};
            ULWP_OFF_REVISION:  rdata = ULWP_REVISION;
            default:            rdata = 32'h0000_0000;
        endcase
    end

    // One wait-free ack per request, dropped the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Read data only beside ack; zero otherwise so stale values never leak
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= rd ? rdata : 32'h0000_0000;
        end
    end

    // Configuration outputs, registered so the engine sees clean levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            response_action_o <= ULWP_ACT_PUBLISH;
        end else begin
            response_action_o <= ulwp_action_t'(linmode_q[ULWP_ACT_LSB +: 2]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ident_tx_o <= 8'h00;
        end else begin
            ident_tx_o <= ident_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= 4'h0;
        end else begin
            mode_o <= mode_q[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            receiver_timeout_value_o <= '0;
        end else begin
            receiver_timeout_value_o <= rto_q;
        end
    end
endmodule

/* File: tb/ulwp_regs_monitor.sv */
`timescale 1ns/1ns
module ulwp_regs_monitor (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [31:0]           wb_dat_o,
    input  wire logic                  wb_ack_o,
    // Outputs watched
    input  wire ulwp_pkg::ulwp_action_t response_action_o,
    input  wire logic [7:0]            ident_tx_o,
    input  wire logic [3:0]            mode_o,
    input  wire logic [16:0]           receiver_timeout_value_o,
    input  wire logic                  div_tick_o
);
    import ulwp_pkg::*;
    logic      prot_q;
    wire logic wr_ack = wb_ack_o && wb_we_i;
    wire logic rd_ack = wb_ack_o && !wb_we_i;
    // Shadow of the enable, so protected writes can be judged at the ports
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_q <= 1'b0;
        end else if (wr_ack && wb_adr_i == ULWP_OFF_WPMODE
                     && wb_dat_i[31:8] == ULWP_PROTECT_KEY) begin
            prot_q <= wb_dat_i[0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence gap_s;
        !div_tick_o [*7] ##1 div_tick_o;
    endsequence
    ack_latency_a: assert property (req_s |=> wb_ack_o) else $error("ack late");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("data without ack");
    action_write_a: assert property (wr_ack && wb_adr_i == ULWP_OFF_LINMODE && wb_sel_i[0]
        |=> response_action_o == $past(wb_dat_i[1:0])) else $error("action not taken");
    ident_master_a: assert property (wr_ack && wb_adr_i == ULWP_OFF_IDENT && wb_sel_i[0]
        && mode_o == ULWP_MODE_LIN_MASTER |=> ident_tx_o == $past(wb_dat_i[7:0]))
        else $error("ident not taken");
    timeout_width_a: assert property (wr_ack && wb_adr_i == ULWP_OFF_RXTIMEOUT
        && &wb_sel_i && !prot_q |=> receiver_timeout_value_o == $past(wb_dat_i[16:0]))
        else $error("timeout value wrong");
    protect_hold_a: assert property (wr_ack && wb_adr_i == ULWP_OFF_MODE && prot_q
        |=> mode_o == $past(mode_o, 2)) else $error("protected mode changed");
    key_zero_a: assert property (rd_ack && wb_adr_i == ULWP_OFF_WPMODE
        |-> wb_dat_o == {31'h0, prot_q}) else $error("protect mode readback");
    baud_upper_a: assert property (rd_ack && wb_adr_i == ULWP_OFF_BAUDRB
        |-> wb_dat_o[31:19] == 13'h0) else $error("readback upper bits");
    revision_ro_a: assert property (rd_ack && wb_adr_i == ULWP_OFF_REVISION
        |-> wb_dat_o == ULWP_REVISION) else $error("revision wrong");
    tick_gap_a: assert property (div_tick_o |=> gap_s) else $error("tick period");
endmodule
bind ulwp_regs ulwp_regs_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .response_action_o(response_action_o),
    .ident_tx_o(ident_tx_o), .mode_o(mode_o),
    .receiver_timeout_value_o(receiver_timeout_value_o), .div_tick_o(div_tick_o)
);

/* File: tb/ulwp_lin_node.sv */
`timescale 1ns/1ns
module ulwp_lin_node (
    // Clock
    input  wire logic  clk_i,
    // Toward the block
    output logic       ident_rx_valid_o,
    output logic [7:0] ident_rx_o,
    output logic       sync_done_o,
    output logic [15:0] sync_clock_divider_o,
    output logic [2:0] sync_frac_part_o
);
    initial begin
        ident_rx_valid_o = 1'b0;
        ident_rx_o = 8'hA5;
        sync_done_o = 1'b0;
        sync_clock_divider_o = 16'hA5A5;
        sync_frac_part_o = 3'h2;
    end
    // Unqualified lines carry the inverse, so a stale value never looks fresh
    task automatic send_ident(input logic [7:0] v);
        @(posedge clk_i);
        ident_rx_valid_o <= 1'b1;
        ident_rx_o <= v;
        @(posedge clk_i);
        ident_rx_valid_o <= 1'b0;
        ident_rx_o <= ~v;
    endtask
    task automatic finish_sync(input logic [15:0] d, input logic [2:0] f);
        @(posedge clk_i);
        sync_done_o <= 1'b1;
        sync_clock_divider_o <= d;
        sync_frac_part_o <= f;
        @(posedge clk_i);
        sync_done_o <= 1'b0;
        sync_clock_divider_o <= ~d;
        sync_frac_part_o <= ~f;
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module testbench;
    import ulwp_pkg::*;
    localparam logic [7:0] PROT_OFFS [7] = '{ULWP_OFF_MODE, ULWP_OFF_BAUDGEN,
        ULWP_OFF_RXTIMEOUT, ULWP_OFF_TIMEGUARD, ULWP_OFF_CLKRATIO, ULWP_OFF_IRFILTER,
        ULWP_OFF_MANCH};
    logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, div_tick_o, irq_o;
    logic         id_vld, sync_done;
    logic [7:0]   wb_adr_i, id_rx, ident_tx_o;
    logic [3:0]   wb_sel_i, mode_o;
    logic [31:0]  wb_dat_i, wb_dat_o, rdat, b;
    logic [15:0]  sync_div;
    logic [2:0]   sync_frac;
    logic [16:0]  rto;
    ulwp_action_t act;
    int           failures, checks, n;

    ulwp_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ident_rx_valid_i(id_vld),
        .ident_rx_i(id_rx), .sync_done_i(sync_done), .sync_clock_divider_i(sync_div),
        .sync_frac_part_i(sync_frac), .response_action_o(act), .ident_tx_o(ident_tx_o),
        .mode_o(mode_o), .receiver_timeout_value_o(rto), .div_tick_o(div_tick_o),
        .irq_o(irq_o));
    ulwp_lin_node node (.clk_i(clk_i), .ident_rx_valid_o(id_vld), .ident_rx_o(id_rx),
        .sync_done_o(sync_done), .sync_clock_divider_o(sync_div),
        .sync_frac_part_o(sync_frac));

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) failures++;
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK(rdat, e)
    endtask

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #(40 * 5000);
        failures++;
        wrap_up();
    end
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b1000;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0000_0000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(ULWP_OFF_IDENT, 32'h0000_0000);
        rd_chk(ULWP_OFF_WPSTAT, 32'h0000_0000);
        rd_chk(8'h80, 32'h0000_0000);
        xfer(1'b1, ULWP_OFF_REVISION, 32'hFFFF_FFFF);
        rd_chk(ULWP_OFF_REVISION, ULWP_REVISION);
        // Reserved action code is never programmed
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, ULWP_OFF_LINMODE, 32'(i));
            rd_chk(ULWP_OFF_LINMODE, 32'(i));
            `CHK(act, ulwp_action_t'(i))
        end
        xfer(1'b1, ULWP_OFF_RXTIMEOUT, 32'hFFFF_FFFF);
        rd_chk(ULWP_OFF_RXTIMEOUT, 32'h0001_FFFF);
        `CHK(rto, 17'h1_FFFF)
        xfer(1'b1, ULWP_OFF_MODE, {28'h0, ULWP_MODE_LIN_MASTER});
        xfer(1'b1, ULWP_OFF_IDENT, 32'h0000_005A);
        rd_chk(ULWP_OFF_IDENT, 32'h0000_005A);
        `CHK(ident_tx_o, 8'h5A)
        xfer(1'b1, ULWP_OFF_MODE, {28'h0, ULWP_MODE_LIN_SLAVE});
        node.send_ident(8'h33);
        rd_chk(ULWP_OFF_IDENT, 32'h0000_0033);
        xfer(1'b1, ULWP_OFF_IDENT, 32'h0000_0077);
        rd_chk(ULWP_OFF_IDENT, 32'h0000_0033);
        node.finish_sync(16'h1234, 3'h5);
        rd_chk(ULWP_OFF_BAUDRB, 32'h0005_1234);
        xfer(1'b1, ULWP_OFF_BAUDRB, 32'h0000_0000);
        rd_chk(ULWP_OFF_BAUDRB, 32'h0005_1234);
        n = 0;
        while (div_tick_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (div_tick_o !== 1'b1 && n < 20);
        `CHK(n, 8)
        xfer(1'b1, ULWP_OFF_WPMODE, 32'h1234_5601);
        rd_chk(ULWP_OFF_WPMODE, 32'h0000_0000);
        xfer(1'b1, ULWP_OFF_WPMODE, {ULWP_PROTECT_KEY, 8'h01});
        rd_chk(ULWP_OFF_WPMODE, 32'h0000_0001);
        xfer(1'b1, ULWP_OFF_WPMODE, 32'h0000_0000);
        rd_chk(ULWP_OFF_WPMODE, 32'h0000_0001);
        foreach (PROT_OFFS[k]) begin
            xfer(1'b0, PROT_OFFS[k], 32'h0000_0000);
            b = rdat;
            xfer(1'b1, PROT_OFFS[k], ~b);
            rd_chk(PROT_OFFS[k], b);
            rd_chk(ULWP_OFF_WPSTAT, {16'h0, PROT_OFFS[k], 8'h01});
            rd_chk(ULWP_OFF_WPSTAT, 32'h0000_0000);
        end
        `CHK(mode_o, ULWP_MODE_LIN_SLAVE)
        `CHK(irq_o, 1'b0)
        xfer(1'b1, ULWP_OFF_IRQ_EN, 32'h0000_0001);
        xfer(1'b0, ULWP_OFF_IRQ_STAT, 32'h0000_0000);
        `CHK(rdat[0], 1'b1)
        `CHK(irq_o, 1'b1)
        xfer(1'b1, ULWP_OFF_IRQ_CLR, 32'h0000_0001);
        xfer(1'b0, ULWP_OFF_IRQ_STAT, 32'h0000_0000);
        `CHK(rdat[0], 1'b0)
        `CHK(irq_o, 1'b0)
        xfer(1'b1, ULWP_OFF_WPMODE, {ULWP_PROTECT_KEY, 8'h00});
        xfer(1'b1, ULWP_OFF_MODE, {28'h0, ULWP_MODE_LIN_MASTER});
        rd_chk(ULWP_OFF_MODE, {28'h0, ULWP_MODE_LIN_MASTER});
        `CHK(mode_o, ULWP_MODE_LIN_MASTER)
        wrap_up();
    end
endmodule
